//--- logic/gpx_regs.svh
// register offsets, reset values and timing constants of the port expander
`ifndef GPX_REGS_SVH
`define GPX_REGS_SVH
`define GPX_PTR_INPUT      8'h00
`define GPX_PTR_OUTPUT     8'h01
`define GPX_PTR_INVERT     8'h02
`define GPX_PTR_DIRECTION  8'h03
`define GPX_PTR_TIMEOUT    8'h04
`define GPX_PTR_RESERVED   8'hFF
`define GPX_RST_OUTPUT     8'h00
`define GPX_RST_INVERT     8'hF0
`define GPX_RST_DIRECTION  8'hFF
`define GPX_RST_TIMEOUT    8'h01
`define GPX_TO_EN_BIT      0
`define GPX_ADDR_HI_ZERO   2'b00
`define GPX_ADDR_SEL_W     5
`define GPX_TIMEOUT_MS     30
`define GPX_CLK_KHZ        50_000
`define GPX_TIMEOUT_CYC    (`GPX_TIMEOUT_MS * `GPX_CLK_KHZ)
`endif

//--- logic/gpx_pkg.sv
// types shared by the port expander
package gpx_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_PTR,
		ST_WDATA,
		ST_RDATA,
		ST_ACK,
		ST_RACK,
		ST_IGNORE
	} gpx_state_t;
endpackage : gpx_pkg

//--- logic/gpx_expander.sv
// two-wire eight-bit port expander, slave side
// Function
// - accept seven-bit slave address then direction bit, low write high read
// - top address bits zero; select pins pick one of 32 addresses
// - lines idle high; detect start and stop while clock high
// - one bit per clock pulse; sender holds data while clock high
// - ninth clock is acknowledge; receiver pulls data low through it
// - first byte after address is the register pointer
// - pointer 0x00 reads pin levels whatever the direction; writes ignored
// - pointer 0x01 drives output pins; reads return stored value
// - polarity bit set inverts the reported input level
// - direction bit one makes pin input, zero makes it output
// - timeout register bit zero enables the bus timeout
// - line low beyond limit after start resets interface, releases data
// - clock stalled high or low during our access resets interface
// - external reset low forces all eight pins to inputs
// - pin zero is open drain, drives only low
// - polarity resets to upper ones lower zeros; direction all ones
// - timeout enable bit resets to one
`timescale 1ns/100ps
`default_nettype none
`include "gpx_regs.svh"
module gpx_expander #(
	parameter int TIMEOUT_CYC = `GPX_TIMEOUT_CYC
) (
	// clock and reset
	input  wire logic       I_SYS_CLK,
	input  wire logic       I_RST,
	input  wire logic       I_RESET_N,
	// two-wire bus
	input  wire logic       I_SCL,
	input  wire logic       I_SDA,
	output logic            O_SDA,
	output logic            O_SDA_OE_N,
	// address select pins, decoded to five address bits outside
	input  wire logic [4:0] I_ADDR_SEL,
	// port pins
	input  wire logic [7:0] I_PORT,
	output logic      [7:0] O_PORT,
	output logic      [7:0] O_PORT_OE_N
);
	if (TIMEOUT_CYC < 2) begin : g_bad_timeout
		$error("TIMEOUT_CYC too small");
	end

	function automatic logic agree(input logic [2:0] s);
		agree = s[1] == s[2];
	endfunction : agree

	// three-stage sync; change counted once stages two and three agree
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic [2:0] rstn_sync_reg;
	logic [2:0] port_sync_reg [8];
	logic [2:0] asel_sync_reg [`GPX_ADDR_SEL_W];
	logic [4:0] asel_reg;
	logic       scl_reg;
	logic       sda_reg;
	logic       rstn_reg;
	logic [7:0] port_reg;
	logic       scl_prev_reg;
	logic       sda_prev_reg;

	always_ff @(posedge I_SYS_CLK) begin
		scl_sync_reg  <= {scl_sync_reg[1:0], I_SCL};
		sda_sync_reg  <= {sda_sync_reg[1:0], I_SDA};
		rstn_sync_reg <= {rstn_sync_reg[1:0], I_RESET_N};
		for (int i = 0; i < 8; i++)
			port_sync_reg[i] <= {port_sync_reg[i][1:0], I_PORT[i]};
		// select pins are meant static; synced so a strap change is clean
		for (int i = 0; i < `GPX_ADDR_SEL_W; i++)
			asel_sync_reg[i] <= {asel_sync_reg[i][1:0], I_ADDR_SEL[i]};
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			scl_reg      <= 1'b1;
			sda_reg      <= 1'b1;
			rstn_reg     <= 1'b1;
			asel_reg     <= 5'h00;
			port_reg     <= 8'h00;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			if (agree(scl_sync_reg))
				scl_reg <= scl_sync_reg[2];
			if (agree(sda_sync_reg))
				sda_reg <= sda_sync_reg[2];
			if (agree(rstn_sync_reg))
				rstn_reg <= rstn_sync_reg[2];
			for (int i = 0; i < `GPX_ADDR_SEL_W; i++)
				if (agree(asel_sync_reg[i]))
					asel_reg[i] <= asel_sync_reg[i][2];
			for (int i = 0; i < 8; i++)
				if (agree(port_sync_reg[i]))
					port_reg[i] <= port_sync_reg[i][2];
			scl_prev_reg <= scl_reg;
			sda_prev_reg <= sda_reg;
		end
	end

	// bus events
	wire scl_rise = scl_reg & ~scl_prev_reg;
	wire scl_fall = ~scl_reg & scl_prev_reg;
	wire start_ev = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
	wire stop_ev  = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;

	// registers
	logic [7:0] out_reg;
	logic [7:0] inv_reg;
	logic [7:0] dir_reg;
	logic [7:0] tmo_reg;
	logic [7:0] ptr_reg;

	gpx_pkg::gpx_state_t state_reg;
	gpx_pkg::gpx_state_t ack_ret_reg;
	logic [7:0]          shift_reg;
	logic [3:0]          bit_cnt_reg;
	logic                rw_reg;
	logic                sda_low_reg;
	logic                ack_pend_reg;
	logic [31:0]         tmo_cnt_reg;

	// slave address: two high bits zero, five from the select pins
	wire [6:0] own_addr   = {`GPX_ADDR_HI_ZERO, asel_reg};
	wire [7:0] byte_in    = {shift_reg[6:0], sda_reg};
	wire       addr_match = byte_in[7:1] == own_addr;
	wire [7:0] in_view    = port_reg ^ inv_reg;

	// pointer read mux; unmapped pointers read zero
	wire [7:0] rd_data =
		(ptr_reg == `GPX_PTR_INPUT)     ? in_view :
		(ptr_reg == `GPX_PTR_OUTPUT)    ? out_reg :
		(ptr_reg == `GPX_PTR_INVERT)    ? inv_reg :
		(ptr_reg == `GPX_PTR_DIRECTION) ? dir_reg :
		(ptr_reg == `GPX_PTR_TIMEOUT)   ? tmo_reg : 8'h00;

	// timeout: any line low, or clock frozen mid-access, too long
	wire busy      = state_reg != gpx_pkg::ST_IDLE;
	wire ours      = busy && state_reg != gpx_pkg::ST_IGNORE;
	wire stall     = ~scl_reg | ~sda_reg | ours;
	wire to_en     = tmo_reg[`GPX_TO_EN_BIT];
	wire to_fire   = to_en && busy && tmo_cnt_reg >= 32'(TIMEOUT_CYC - 1);
	wire line_edge = scl_rise | scl_fall;

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || !busy || !to_en || line_edge || !stall)
			tmo_cnt_reg <= 32'h0000_0000;
		else if (!to_fire)
			tmo_cnt_reg <= tmo_cnt_reg + 32'h0000_0001;
	end

	// serial engine; writes land on the ack bit of each data byte
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			state_reg    <= gpx_pkg::ST_IDLE;
			ack_ret_reg  <= gpx_pkg::ST_IDLE;
			shift_reg    <= 8'h00;
			bit_cnt_reg  <= 4'h0;
			rw_reg       <= 1'b0;
			sda_low_reg  <= 1'b0;
			ack_pend_reg <= 1'b0;
			ptr_reg      <= 8'h00;
			out_reg      <= `GPX_RST_OUTPUT;
			inv_reg      <= `GPX_RST_INVERT;
			dir_reg      <= `GPX_RST_DIRECTION;
			tmo_reg      <= `GPX_RST_TIMEOUT;
		end else if (to_fire || stop_ev) begin
			state_reg   <= gpx_pkg::ST_IDLE;
			sda_low_reg <= 1'b0;
		end else if (start_ev) begin
			state_reg   <= gpx_pkg::ST_ADDR;
			bit_cnt_reg <= 4'h0;
			sda_low_reg <= 1'b0;
		end else if (scl_rise) begin
			unique case (state_reg)
			gpx_pkg::ST_ADDR, gpx_pkg::ST_PTR, gpx_pkg::ST_WDATA: begin
				shift_reg   <= byte_in;
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
			gpx_pkg::ST_RACK:
				// master nack ends the read
				if (sda_reg)
					state_reg <= gpx_pkg::ST_IGNORE;
			default: ;
			endcase
		end else if (scl_fall) begin
			unique case (state_reg)
			gpx_pkg::ST_ADDR:
				if (bit_cnt_reg == 4'h8) begin
					if (shift_reg[7:1] == own_addr) begin
						rw_reg      <= shift_reg[0];
						sda_low_reg <= 1'b1;
						ack_ret_reg <= shift_reg[0] ? gpx_pkg::ST_RDATA
							: gpx_pkg::ST_PTR;
						state_reg   <= gpx_pkg::ST_ACK;
					end else
						state_reg <= gpx_pkg::ST_IGNORE;
				end
			gpx_pkg::ST_PTR:
				if (bit_cnt_reg == 4'h8) begin
					ptr_reg     <= shift_reg;
					sda_low_reg <= 1'b1;
					ack_ret_reg <= gpx_pkg::ST_WDATA;
					state_reg   <= gpx_pkg::ST_ACK;
				end
			gpx_pkg::ST_WDATA:
				if (bit_cnt_reg == 4'h8) begin
					unique case (ptr_reg)
					`GPX_PTR_OUTPUT:    out_reg <= shift_reg;
					`GPX_PTR_INVERT:    inv_reg <= shift_reg;
					`GPX_PTR_DIRECTION: dir_reg <= shift_reg;
					`GPX_PTR_TIMEOUT:   tmo_reg <= shift_reg;
					// input and reserved pointers ignore writes
					default: ;
					endcase
					sda_low_reg <= 1'b1;
					ack_ret_reg <= gpx_pkg::ST_WDATA;
					state_reg   <= gpx_pkg::ST_ACK;
				end
			gpx_pkg::ST_ACK: begin
				bit_cnt_reg <= 4'h0;
				state_reg   <= ack_ret_reg;
				if (ack_ret_reg == gpx_pkg::ST_RDATA) begin
					shift_reg   <= rd_data;
					sda_low_reg <= ~rd_data[7];
				end else
					sda_low_reg <= 1'b0;
			end
			gpx_pkg::ST_RDATA:
				if (bit_cnt_reg == 4'h7) begin
					sda_low_reg <= 1'b0; // release for master ack
					state_reg   <= gpx_pkg::ST_RACK;
				end else begin
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					shift_reg   <= {shift_reg[6:0], 1'b0};
					sda_low_reg <= ~shift_reg[6];
				end
			gpx_pkg::ST_RACK: begin
				// master acked: next byte from the same pointer
				shift_reg   <= rd_data;
				bit_cnt_reg <= 4'h0;
				sda_low_reg <= ~rd_data[7];
				state_reg   <= gpx_pkg::ST_RDATA;
			end
			default: ;
			endcase
		end
	end

	// output drivers, all straight from flip-flops
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			O_SDA       <= 1'b0;
			O_SDA_OE_N  <= 1'b1;
			O_PORT      <= 8'h00;
			O_PORT_OE_N <= 8'hFF;
		end else begin
			O_SDA      <= 1'b0;
			O_SDA_OE_N <= ~sda_low_reg;
			O_PORT     <= out_reg;
			// external reset overrides: every pin an input
			if (!rstn_reg)
				O_PORT_OE_N <= 8'hFF;
			else
				O_PORT_OE_N <= {dir_reg[7:1], dir_reg[0] | out_reg[0]};
		end
	end

	// checks on the serial engine and the pin drivers
	a_sda_released: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) $past(to_fire) |-> ##1 O_SDA_OE_N)
		else $error("sda not released after timeout");

	a_ext_reset_inputs: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) !rstn_reg |=> O_PORT_OE_N == 8'hFF)
		else $error("pins driven during external reset");

	a_pin0_open_drain: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) !O_PORT_OE_N[0] |-> !O_PORT[0])
		else $error("pin zero driven high");

	a_dir_output: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) rstn_reg && !dir_reg[1]
		|=> !O_PORT_OE_N[1] && O_PORT[1] == $past(out_reg[1]))
		else $error("output pin not driven");

	a_start_seen: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) start_ev && !to_fire
		|=> state_reg == gpx_pkg::ST_ADDR)
		else $error("start not detected");

	a_stop_idle: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) stop_ev
		|=> state_reg == gpx_pkg::ST_IDLE ##1 O_SDA_OE_N)
		else $error("stop not detected");

	a_input_view: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) state_reg == gpx_pkg::ST_ACK && scl_fall &&
		ack_ret_reg == gpx_pkg::ST_RDATA && ptr_reg == `GPX_PTR_INPUT &&
		!to_fire |=> shift_reg == $past(port_reg ^ inv_reg))
		else $error("input read wrong");

	a_ack_addr: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) state_reg == gpx_pkg::ST_ADDR && scl_fall &&
		bit_cnt_reg == 4'h8 && shift_reg[7:1] == own_addr && !to_fire &&
		!stop_ev && !start_ev |=> ##1 !O_SDA_OE_N)
		else $error("address not acknowledged");

	a_timeout_off: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) !to_en && busy && !stop_ev
		|=> state_reg != gpx_pkg::ST_IDLE)
		else $error("interface reset while timeout disabled");

	a_hold_stable: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) scl_reg && scl_prev_reg && !start_ev &&
		!stop_ev && !to_fire |=> $stable(sda_low_reg))
		else $error("sda changed while clock high");

	a_foreign_ignored: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) state_reg == gpx_pkg::ST_ADDR && scl_fall &&
		bit_cnt_reg == 4'h8 && shift_reg[7:6] != `GPX_ADDR_HI_ZERO &&
		!to_fire |=> state_reg == gpx_pkg::ST_IGNORE)
		else $error("foreign address not ignored");

	a_ptr_capture: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) state_reg == gpx_pkg::ST_PTR && scl_fall &&
		bit_cnt_reg == 4'h8 && !to_fire |=> ptr_reg == $past(shift_reg))
		else $error("pointer not captured");

	a_out_write: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) state_reg == gpx_pkg::ST_WDATA && scl_fall &&
		bit_cnt_reg == 4'h8 && ptr_reg == `GPX_PTR_OUTPUT && !to_fire
		|=> out_reg == $past(shift_reg))
		else $error("output register not written");

	a_input_ro: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) state_reg == gpx_pkg::ST_WDATA &&
		ptr_reg == `GPX_PTR_INPUT
		|=> $stable(out_reg) && $stable(inv_reg) &&
		$stable(dir_reg) && $stable(tmo_reg))
		else $error("write to input register landed");

	a_quiet_released: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) !ours && !$past(ours) |-> O_SDA_OE_N)
		else $error("sda driven while not addressed");

	a_timeout_idle: assert property (@(posedge I_SYS_CLK)
		disable iff (I_RST) to_fire |=> state_reg == gpx_pkg::ST_IDLE)
		else $error("interface not reset by timeout");
endmodule : gpx_expander
`default_nettype wire

//--- verification/gpx_master.sv
// two-wire bus master model facing the expander
`timescale 1ns/100ps
`default_nettype none
module gpx_master (
	// clock
	input  wire logic i_clk,
	// bus lines, sda released means pulled up
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge i_clk);
	endtask : wt
	// data moves mid low phase, so it never changes while the clock is high
	task automatic bit_io(input logic b, input int hold, output logic seen);
		o_scl <= 1'b0;
		wt(5);
		o_sda <= b;
		wt(5);
		o_scl <= 1'b1;
		wt(5);
		seen = i_sda;
		wt(5 + hold);
	endtask : bit_io
	task automatic start;
		o_sda <= 1'b0;
		wt(10);
	endtask : start
	task automatic stop;
		logic s;
		bit_io(1'b0, 0, s);
		o_sda <= 1'b1;
		wt(10);
	endtask : stop
	// msb first, ninth clock left released for the ack
	task automatic put_byte(input logic [7:0] d, input int stall,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], 0, s);
		bit_io(1'b1, stall, ack);
	endtask : put_byte
	task automatic get_byte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, 0, d[i]);
		bit_io(nack, 0, s);
	endtask : get_byte
	// callers never hand pointer 0xFF to a write
	task automatic wr(input logic [6:0] a, input logic [7:0] p,
		input logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		put_byte({a, 1'b0}, 0, a0);
		put_byte(p, 0, a1);
		put_byte(d, 0, a2);
		stop();
		ok = !(a0 | a1 | a2);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] p,
		output logic [7:0] d);
		logic a0;
		start();
		put_byte({a, 1'b0}, 0, a0);
		put_byte(p, 0, a0);
		stop();
		start();
		put_byte({a, 1'b1}, 0, a0);
		get_byte(1'b1, d);
		stop();
	endtask : rd
endmodule : gpx_master
`default_nettype wire

//--- verification/gpx_expander_bench.sv
// self-checking bench for the port expander
`timescale 1ns/100ps
`default_nettype none
module gpx_expander_bench;
	localparam logic [6:0] ADDR = 7'h15;
	localparam logic [7:0] EXT = 8'h3D;
	logic       clk, rst, reset_n;
	logic [4:0] asel;
	logic       scl, sda_m, o_sda, sda_oe_n;
	logic [7:0] o_port, oe_n;
	wire  logic sda = sda_m & (sda_oe_n | o_sda);
	// pins: driven where enabled, outside level elsewhere
	wire  logic [7:0] pins = (oe_n & EXT) | (~oe_n & o_port);
	int n_fail = 0;
	int comparisons = 0;
	gpx_master mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));
	gpx_expander #(.TIMEOUT_CYC(200)) uut (.I_SYS_CLK(clk), .I_RST(rst),
		.I_RESET_N(reset_n), .I_SCL(scl), .I_SDA(sda), .O_SDA(o_sda),
		.O_SDA_OE_N(sda_oe_n), .I_ADDR_SEL(asel), .I_PORT(pins),
		.O_PORT(o_port), .O_PORT_OE_N(oe_n));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic stop_test;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic t_reset_vals;
		logic [7:0] d;
		mst.rd(ADDR, 8'h01, d);
		chk("out", d, 8'h00);
		mst.rd(ADDR, 8'h02, d);
		chk("inv", d, 8'hF0);
		mst.rd(ADDR, 8'h03, d);
		chk("dir", d, 8'hFF);
		mst.rd(ADDR, 8'h04, d);
		chk("tmo", {7'h0, d[0]}, 8'h01);
		mst.rd(ADDR, 8'h00, d);
		chk("in", d, EXT ^ 8'hF0);
	endtask : t_reset_vals
	task automatic t_ports;
		logic [7:0] d;
		logic ok;
		mst.wr(ADDR, 8'h03, 8'h00, ok);
		chk("wr ack", {7'h0, ok}, 8'h01);
		mst.wr(ADDR, 8'h01, 8'hA4, ok);
		chk("oe", oe_n, 8'h00);
		chk("port", o_port, 8'hA4);
		mst.wr(ADDR, 8'h01, 8'hA5, ok);
		chk("oe0", oe_n, 8'h01);
		mst.rd(ADDR, 8'h00, d);
		chk("in xor", d, 8'h55);
		mst.wr(ADDR, 8'h00, 8'h00, ok);
		chk("ro ack", {7'h0, ok}, 8'h01);
		mst.rd(ADDR, 8'h01, d);
		chk("out kept", d, 8'hA5);
	endtask : t_ports
	task automatic t_ext_reset;
		reset_n <= 1'b0;
		repeat (10) @(posedge clk);
		chk("ext rst", oe_n, 8'hFF);
		reset_n <= 1'b1;
		repeat (10) @(posedge clk);
		chk("ext rel", oe_n, 8'h01);
	endtask : t_ext_reset
	task automatic t_bad_addr;
		logic ok;
		mst.wr(7'h55, 8'h01, 8'h00, ok);
		chk("bad addr", {7'h0, ok}, 8'h00);
		chk("port", o_port, 8'hA5);
		asel <= 5'h0A;
		repeat (10) @(posedge clk);
		mst.wr(7'h0A, 8'h01, 8'hA4, ok);
		chk("alt addr", o_port, 8'hA4);
		asel <= ADDR[4:0];
		repeat (10) @(posedge clk);
	endtask : t_bad_addr
	// clock held high on the ack clock, with the device pulling data low
	task automatic t_timeout(input logic rel);
		logic a;
		mst.start();
		mst.put_byte({ADDR, 1'b0}, 400, a);
		chk("ack", {7'h0, a}, 8'h00);
		chk("sda rel", {7'h0, sda_oe_n}, {7'h0, rel});
		mst.stop();
	endtask : t_timeout
	task automatic t_tmo_disable;
		logic [7:0] d;
		logic ok;
		mst.wr(ADDR, 8'h04, 8'h00, ok);
		chk("tmo wr", {7'h0, ok}, 8'h01);
		mst.rd(ADDR, 8'h04, d);
		chk("tmo off", {7'h0, d[0]}, 8'h00);
		t_timeout(1'b0);
	endtask : t_tmo_disable
	initial begin
		rst = 1'b1;
		reset_n = 1'b1;
		asel = ADDR[4:0];
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		t_reset_vals();
		t_ports();
		t_ext_reset();
		t_bad_addr();
		t_timeout(1'b1);
		t_tmo_disable();
		stop_test();
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		stop_test();
	end
endmodule : gpx_expander_bench
`default_nettype wire
